// ===== hw/cmd_decoder_params.svh
`ifndef CMD_DECODER_PARAMS_SVH
`define CMD_DECODER_PARAMS_SVH
// Command word bit positions
`define CW_OFF1 0
`define CW_OFF2 1
`define CW_OFF3 2
`define CW_COAST 3
`define CW_QSTOP 4
`define CW_HOLD 5
`define CW_RAMP 6
`define CW_RESET 7
`define CW_JOG1 8
`define CW_JOG2 9
`define CW_VALID 10
`define CW_SLOW 11
`define CW_CATCH 12
`define CW_SET_LSB 13
`define CW_SET_MSB 14
`define CW_REV 15
// Relative scaling: 100 percent code
`define REF_FULL_SCALE 16'h4000
`define REF_MAX_POS 16'h7fff
`define REF_MIN_NEG 16'h8000
// Reset values
`define CMD_RESET_VAL 16'h0000
`define REF_RESET_VAL 16'h0000
// Digital-input combine selections
`define SEL_DIN 2'h0
`define SEL_BUS 2'h1
`define SEL_AND 2'h2
`define SEL_OR 2'h3
`endif

// ===== hw/cmd_decoder_pkg.sv
package cmd_decoder_pkg;
   typedef enum logic [2:0] {
      STOP_NONE = 3'b000,
      STOP_RAMP = 3'b001,
      STOP_COAST = 3'b010,
      STOP_QUICK = 3'b011,
      STOP_HELD = 3'b100
   } stop_mode_t;
   typedef enum logic [1:0] {
      REFSEL_BUS = 2'b00,
      REFSEL_JOG1 = 2'b01,
      REFSEL_JOG2 = 2'b10
   } ref_src_t;
endpackage

// ===== hw/cmd_latch.sv
`timescale 1ns/1ns
`default_nettype none
`include "cmd_decoder_params.svh"
module cmd_latch (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [15:0] raw_word_i,
   cmd_word_if.src cmd
);
   logic [15:0] word_q;
   logic rst_bit_q;
   logic pulse_q;
   // Ignored words leave the held command untouched
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         word_q <= `CMD_RESET_VAL;
      end else if (raw_word_i[`CW_VALID]) begin
         word_q <= raw_word_i;
      end
   end
   // Edge taken only on accepted words; a level never retriggers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rst_bit_q <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         pulse_q <= raw_word_i[`CW_VALID] & raw_word_i[`CW_RESET] & ~rst_bit_q;
         if (raw_word_i[`CW_VALID]) begin
            rst_bit_q <= raw_word_i[`CW_RESET];
         end
      end
   end
   assign cmd.word = word_q;
   assign cmd.valid = word_q[`CW_VALID];
   assign cmd.fault_reset = pulse_q;
endmodule
`default_nettype wire

// ===== hw/cmd_word_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cmd_word_if;
   logic [15:0] word;
   logic valid;
   logic fault_reset;
   modport src (output word, output valid, output fault_reset);
   modport dst (input word, input valid, input fault_reset);
endinterface
`default_nettype wire

// ===== hw/drive_fieldbus_command_decoder.sv
`timescale 1ns/1ns
`default_nettype none
`include "cmd_decoder_params.svh"
module drive_fieldbus_command_decoder (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic [15:0] COMMAND_WORD_I,
   input wire logic [15:0] SPEED_REF_I,
   input wire logic [15:0] OUT_FREQ_I,
   input wire logic [15:0] ADJUST_VALUE_I,
   input wire logic [15:0] JOG1_SPEED_I,
   input wire logic [15:0] JOG2_SPEED_I,
   input wire logic RELAY_ZERO_SEL_I,
   input wire logic MOTOR_RUNNING_I,
   input wire logic MULTI_SETUP_I,
   input wire logic SETUPS_LINKED_I,
   input wire logic [1:0] COAST_SEL_I,
   input wire logic [1:0] QSTOP_SEL_I,
   input wire logic [1:0] START_SEL_I,
   input wire logic [1:0] SETUP_SEL_I,
   input wire logic [1:0] REVERSE_SEL_I,
   input wire logic DIN_COAST_I,
   input wire logic DIN_QSTOP_I,
   input wire logic DIN_START_I,
   input wire logic [1:0] DIN_SETUP_I,
   input wire logic DIN_REVERSE_I,
   output logic [2:0] STOP_MODE_O,
   output logic RUN_ENABLE_O,
   output logic HOLD_FREQ_O,
   output logic FAULT_RESET_O,
   output logic [1:0] REF_SOURCE_O,
   output logic [15:0] SPEED_REF_O,
   output logic [1:0] ACTIVE_SETUP_O,
   output logic REVERSE_O,
   output logic RELAY_O,
   output logic [15:0] ACTUAL_OUTPUT_FREQUENCY_VALUE_O
);
   // ==========================================
   // Synchronisers for pin-level inputs
   // ==========================================
   // Pins are asynchronous to CLOCK_I: logic reads only the second stage
   logic [5:0] din_s1_q;
   logic [5:0] din_s2_q;
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         din_s1_q <= 6'h00;
         din_s2_q <= 6'h00;
      end else begin
         din_s1_q <= {DIN_COAST_I, DIN_QSTOP_I, DIN_START_I, DIN_SETUP_I, DIN_REVERSE_I};
         din_s2_q <= din_s1_q;
      end
   end
   logic din_coast;
   logic din_qstop;
   logic din_start;
   logic [1:0] din_setup;
   logic din_rev;
   assign din_coast = din_s2_q[5];
   assign din_qstop = din_s2_q[4];
   assign din_start = din_s2_q[3];
   assign din_setup = din_s2_q[2:1];
   assign din_rev = din_s2_q[0];

   // ==========================================
   // Command capture
   // ==========================================
   cmd_word_if cw ();
   cmd_latch u_latch (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .raw_word_i(COMMAND_WORD_I),
      .cmd(cw.src)
   );
   logic [15:0] w;
   assign w = cw.word;

   // Bits are active-high "permit" levels; both sources agree when 1
   function automatic logic merge(input logic [1:0] sel, input logic bus, input logic din);
      logic r;
      r = din;
      case (sel)
         `SEL_DIN: r = din;
         `SEL_BUS: r = bus;
         `SEL_AND: r = bus & din;
         `SEL_OR: r = bus | din;
         default: r = din;
      endcase
      return r;
   endfunction

   logic coast_ok;
   logic qstop_ok;
   logic start_ok;
   logic rev_req;
   assign coast_ok = merge(COAST_SEL_I, w[`CW_COAST], din_coast);
   assign qstop_ok = merge(QSTOP_SEL_I, w[`CW_QSTOP], din_qstop);
   assign start_ok = merge(START_SEL_I, w[`CW_RAMP], din_start);
   assign rev_req = merge(REVERSE_SEL_I, w[`CW_REV], din_rev);

   logic [1:0] bus_setup;
   logic [1:0] req_setup;
   // Bit 13 is the low bit, bit 14 the high bit; code 0 means set-up 1
   assign bus_setup = {w[`CW_SET_MSB], w[`CW_SET_LSB]};
   assign req_setup = {merge(SETUP_SEL_I, bus_setup[1], din_setup[1]),
                       merge(SETUP_SEL_I, bus_setup[0], din_setup[0])};

   // ==========================================
   // Stop priority and jog
   // ==========================================
   logic jog_ok;
   logic jog_active;
   logic coast_req;
   logic quick_req;
   logic ramp_req;
   logic hold_req;
   // Jog path runs with quick stop low, so it must be checked before stops
   assign jog_ok = ~w[`CW_QSTOP] & (&w[`CW_COAST:`CW_OFF1]);
   assign jog_active = jog_ok & (w[`CW_JOG1] | w[`CW_JOG2]);
   assign coast_req = !w[`CW_OFF2] || !coast_ok;
   assign quick_req = !w[`CW_OFF3] || !qstop_ok;
   assign ramp_req = !w[`CW_OFF1] || !start_ok;
   assign hold_req = !w[`CW_HOLD];
   cmd_decoder_pkg::stop_mode_t stop_d;
   cmd_decoder_pkg::ref_src_t src_d;
   // Jog 1 wins when both jog bits are set
   always_comb begin
      src_d = cmd_decoder_pkg::REFSEL_BUS;
      if (jog_active) begin
         src_d = w[`CW_JOG1] ? cmd_decoder_pkg::REFSEL_JOG1
                             : cmd_decoder_pkg::REFSEL_JOG2;
      end
   end

   always_comb begin
      stop_d = cmd_decoder_pkg::STOP_NONE;
      if (jog_active) begin
         stop_d = cmd_decoder_pkg::STOP_NONE;
      end else if (coast_req) begin
         stop_d = cmd_decoder_pkg::STOP_COAST;
      end else if (quick_req) begin
         stop_d = cmd_decoder_pkg::STOP_QUICK;
      end else if (ramp_req) begin
         stop_d = cmd_decoder_pkg::STOP_RAMP;
      end else if (hold_req) begin
         stop_d = cmd_decoder_pkg::STOP_HELD;
      end
   end

   // ==========================================
   // Stop and run outputs
   // ==========================================
   // Registered so each level changes on one edge only
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         STOP_MODE_O <= cmd_decoder_pkg::STOP_RAMP;
      end else begin
         STOP_MODE_O <= stop_d;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         REF_SOURCE_O <= cmd_decoder_pkg::REFSEL_BUS;
      end else begin
         REF_SOURCE_O <= src_d;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         RUN_ENABLE_O <= 1'b0;
      end else begin
         RUN_ENABLE_O <= (stop_d == cmd_decoder_pkg::STOP_NONE) ||
                         (stop_d == cmd_decoder_pkg::STOP_HELD);
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         HOLD_FREQ_O <= 1'b0;
      end else begin
         HOLD_FREQ_O <= (stop_d == cmd_decoder_pkg::STOP_HELD);
      end
   end

   // ==========================================
   // Relay and fault reset
   // ==========================================
   logic freq_zero;
   logic off_stop;
   assign freq_zero = (OUT_FREQ_I == 16'h0000);
   assign off_stop = !w[`CW_OFF1] || !w[`CW_OFF2] || !w[`CW_OFF3];
   // Relay only once frequency is zero during a stop from bus bit 0, 1 or 2 (OFF1, OFF2, OFF3)
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         RELAY_O <= 1'b0;
      end else begin
         RELAY_O <= RELAY_ZERO_SEL_I && freq_zero && off_stop;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         FAULT_RESET_O <= 1'b0;
      end else begin
         FAULT_RESET_O <= cw.fault_reset;
      end
   end

   // ==========================================
   // Set-up and direction
   // ==========================================
   // Set-up stays put while running unless linked, so parameters never tear mid-run
   logic setup_change_ok;
   assign setup_change_ok = MULTI_SETUP_I && (!MOTOR_RUNNING_I || SETUPS_LINKED_I);
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         ACTIVE_SETUP_O <= 2'h0;
      end else if (setup_change_ok) begin
         ACTIVE_SETUP_O <= req_setup;
      end
   end

   // Bus bit 15 counts only when the reverse selection lets the bus in
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         REVERSE_O <= 1'b0;
      end else begin
         REVERSE_O <= rev_req;
      end
   end

   // ==========================================
   // Reference path
   // ==========================================
   logic [15:0] ref_pick;
   logic [15:0] ref_q;
   // Only a word with the valid bit carries a fresh reference
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         ref_q <= `REF_RESET_VAL;
      end else if (COMMAND_WORD_I[`CW_VALID]) begin
         ref_q <= SPEED_REF_I;
      end
   end

   // Jog speeds bypass the bus reference but still get slow-down and catch-up
   always_comb begin
      case (src_d)
         cmd_decoder_pkg::REFSEL_BUS: ref_pick = ref_q;
         cmd_decoder_pkg::REFSEL_JOG1: ref_pick = JOG1_SPEED_I;
         cmd_decoder_pkg::REFSEL_JOG2: ref_pick = JOG2_SPEED_I;
         default: ref_pick = ref_q;
      endcase
   end
   ref_scaler #(
      .WIDTH(16)
   ) u_scaler (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .ref_i(ref_pick),
      .adj_i(ADJUST_VALUE_I),
      .slow_i(w[`CW_SLOW]),
      .catch_i(w[`CW_CATCH]),
      .ref_o(SPEED_REF_O)
   );

   // ==========================================
   // Frequency feedback
   // ==========================================
   // Frequency passes back unchanged: already in relative, signed form
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         ACTUAL_OUTPUT_FREQUENCY_VALUE_O <= `REF_RESET_VAL;
      end else begin
         ACTUAL_OUTPUT_FREQUENCY_VALUE_O <= OUT_FREQ_I;
      end
   end
endmodule
`default_nettype wire

// ===== hw/ref_scaler.sv
`timescale 1ns/1ns
`default_nettype none
`include "cmd_decoder_params.svh"
module ref_scaler #(
   parameter int WIDTH = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] ref_i,
   input wire logic [WIDTH-1:0] adj_i,
   input wire logic slow_i,
   input wire logic catch_i,
   output logic [WIDTH-1:0] ref_o
);
   // Saturation limits are 16-bit constants, so other widths are refused
   if (WIDTH != 16) begin : width_check
      $error("ref_scaler supports 16-bit words only");
   end
   logic signed [WIDTH:0] sum;
   logic [WIDTH-1:0] ref_q;
   // Saturate rather than wrap: a wrapped reference would reverse the motor
   always_comb begin
      sum = {ref_i[WIDTH-1], ref_i};
      if (slow_i) begin
         sum = $signed({ref_i[WIDTH-1], ref_i}) - $signed({adj_i[WIDTH-1], adj_i});
      end else if (catch_i) begin
         sum = $signed({ref_i[WIDTH-1], ref_i}) + $signed({adj_i[WIDTH-1], adj_i});
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_q <= `REF_RESET_VAL;
      end else if (sum[WIDTH] != sum[WIDTH-1]) begin
         ref_q <= sum[WIDTH] ? `REF_MIN_NEG : `REF_MAX_POS;
      end else begin
         ref_q <= sum[WIDTH-1:0];
      end
   end
   assign ref_o = ref_q;
endmodule
`default_nettype wire

// ===== verif/bus_master_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Fieldbus master: command and reference words
module bus_master_model (
   input wire logic clk_i,
   input wire logic [15:0] cmd_i,
   input wire logic [15:0] ref_i,
   output logic [15:0] command_word_o,
   output logic [15:0] speed_ref_o
);
   // Words change only on an edge, as a real telegram update would
   always_ff @(posedge clk_i) begin
      command_word_o <= cmd_i;
      speed_ref_o <= ref_i;
   end
endmodule
`default_nettype wire

// ===== verif/cmd_decoder_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Port checker
module cmd_decoder_chk (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic [15:0] COMMAND_WORD_I,
   input wire logic [15:0] OUT_FREQ_I,
   input wire logic [2:0] STOP_MODE_O,
   input wire logic RUN_ENABLE_O,
   input wire logic HOLD_FREQ_O,
   input wire logic FAULT_RESET_O,
   input wire logic [15:0] ACTUAL_OUTPUT_FREQUENCY_VALUE_O
);
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (RST_I);
   wire logic ok_w = COMMAND_WORD_I[10];
   pulse_one_a: assert property (FAULT_RESET_O |=> !FAULT_RESET_O)
      else $error("fault reset pulse too long");
   fault_edge_a: assert property (ok_w && !COMMAND_WORD_I[7] ##1 ok_w && COMMAND_WORD_I[7]
      |-> ##2 FAULT_RESET_O) else $error("missing fault reset pulse");
   steady_bit_a: assert property ((ok_w && COMMAND_WORD_I[7]) [*3] |=> !FAULT_RESET_O)
      else $error("fault reset on steady level");
   invalid_quiet_a: assert property (!ok_w [*3] |=> !FAULT_RESET_O)
      else $error("ignored word caused fault reset");
   coast_stop_a: assert property (ok_w && !COMMAND_WORD_I[1]
      |-> ##2 STOP_MODE_O == cmd_decoder_pkg::STOP_COAST) else $error("no coast stop");
   hold_mode_a: assert property (HOLD_FREQ_O == (STOP_MODE_O == cmd_decoder_pkg::STOP_HELD))
      else $error("hold flag disagrees with stop mode");
   run_mode_a: assert property (RUN_ENABLE_O == (STOP_MODE_O == cmd_decoder_pkg::STOP_NONE
      || STOP_MODE_O == cmd_decoder_pkg::STOP_HELD)) else $error("run enable wrong");
   freq_echo_a: assert property (1'b1
      |=> ACTUAL_OUTPUT_FREQUENCY_VALUE_O == $past(OUT_FREQ_I))
      else $error("actual frequency not returned");
   reset_val_a: assert property (disable iff (1'b0) RST_I
      |=> STOP_MODE_O == cmd_decoder_pkg::STOP_RAMP && !RUN_ENABLE_O)
      else $error("reset state wrong");
endmodule
bind drive_fieldbus_command_decoder cmd_decoder_chk chk (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
   .COMMAND_WORD_I(COMMAND_WORD_I), .OUT_FREQ_I(OUT_FREQ_I), .STOP_MODE_O(STOP_MODE_O),
   .RUN_ENABLE_O(RUN_ENABLE_O), .HOLD_FREQ_O(HOLD_FREQ_O), .FAULT_RESET_O(FAULT_RESET_O),
   .ACTUAL_OUTPUT_FREQUENCY_VALUE_O(ACTUAL_OUTPUT_FREQUENCY_VALUE_O));
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin \
   checked++; \
   if ((g) !== (e)) begin \
      $display("BAD %s exp %0h got %0h", n, e, g); \
      err_total++; \
   end \
end
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] cmd = 16'h0000;
   logic [15:0] rf = 16'h0000;
   logic [15:0] ofreq = 16'h0000;
   logic multi = 1'b1;
   logic mrun = 1'b0;
   logic [1:0] sel = 2'h1;
   logic din = 1'b1;
   logic [15:0] cw, sr, sref, afreq;
   logic [2:0] stop_mode;
   logic run_en, hold, fres, rev, relay;
   logic [1:0] rsrc, setup;
   int err_total = 0;
   int checked = 0;
   bus_master_model mst (.clk_i(clk), .cmd_i(cmd), .ref_i(rf), .command_word_o(cw),
      .speed_ref_o(sr));
   // Jog speeds, adjust step, relay zero select and set-up link fixed; the rest are exercised
   drive_fieldbus_command_decoder uut (.CLOCK_I(clk), .RST_I(rst), .COMMAND_WORD_I(cw),
      .SPEED_REF_I(sr), .OUT_FREQ_I(ofreq), .ADJUST_VALUE_I(16'h0100),
      .JOG1_SPEED_I(16'h0800), .JOG2_SPEED_I(16'h1000), .RELAY_ZERO_SEL_I(1'b1),
      .MOTOR_RUNNING_I(mrun), .MULTI_SETUP_I(multi), .SETUPS_LINKED_I(1'b0),
      .COAST_SEL_I(sel), .QSTOP_SEL_I(sel), .START_SEL_I(sel), .SETUP_SEL_I(sel),
      .REVERSE_SEL_I(sel), .DIN_COAST_I(din), .DIN_QSTOP_I(din), .DIN_START_I(din),
      .DIN_SETUP_I({din, din}), .DIN_REVERSE_I(din), .STOP_MODE_O(stop_mode),
      .RUN_ENABLE_O(run_en), .HOLD_FREQ_O(hold), .FAULT_RESET_O(fres), .REF_SOURCE_O(rsrc),
      .SPEED_REF_O(sref), .ACTIVE_SETUP_O(setup), .REVERSE_O(rev), .RELAY_O(relay),
      .ACTUAL_OUTPUT_FREQUENCY_VALUE_O(afreq));
   // ==========================================
   // Bus cycles
   task automatic send(input logic [15:0] w, input logic [15:0] r);
      @(posedge clk);
      cmd <= w;
      rf <= r;
      ofreq <= r;
      repeat (5) @(posedge clk);
      #1;
   endtask
   task automatic pulses(input logic [15:0] w, output int n);
      n = 0;
      @(posedge clk);
      cmd <= w;
      repeat (8) begin
         @(posedge clk);
         #1;
         n += (fres === 1'b1);
      end
   endtask
   // ==========================================
   // Scenarios
   task automatic t_fault();
      int n;
      pulses(16'h047f, n);
      pulses(16'h04ff, n);
      `CHK("pulse on rise", 1, n)
      pulses(16'h04ff, n);
      `CHK("no pulse on level", 0, n)
      pulses(16'h047f, n);
      pulses(16'h00ff, n);
      `CHK("ignored rise", 0, n)
   endtask
   task automatic t_stops();
      logic [15:0] w[9] = '{16'h047e, 16'h047d, 16'h047b, 16'h0477, 16'h046f, 16'h045f,
         16'h043f, 16'h047f, 16'h0000};
      logic [3:0] e[9] = '{4'h3, 4'h5, 4'h7, 4'h4, 4'h6, 4'h8, 4'h2, 4'h0, 4'h0};
      for (int i = 0; i < 9; i++) begin
         send(w[i], 16'h0000);
         `CHK("stop mode and relay", e[i], {stop_mode, relay})
      end
      send(16'h056f, 16'h0000);
      `CHK("jog one", 2'h1, rsrc)
      send(16'h066f, 16'h0000);
      `CHK("jog two", 2'h2, rsrc)
      send(16'h057f, 16'h0000);
      `CHK("jog needs quick stop", 2'h0, rsrc)
   endtask
   task automatic t_ref();
      send(16'h047f, 16'h4000);
      `CHK("full scale ref", 16'h4000, sref)
      send(16'h047f, 16'hc000);
      `CHK("negative ref", 16'hc000, sref)
      `CHK("actual frequency", 16'hc000, afreq)
      send(16'h0c7f, 16'h4000);
      `CHK("slow down", 16'h3f00, sref)
      send(16'h147f, 16'h4000);
      `CHK("catch up", 16'h4100, sref)
      send(16'h1c7f, 16'h4000);
      `CHK("slow wins", 16'h3f00, sref)
      send(16'h147f, 16'h7fff);
      `CHK("catch up clamps", 16'h7fff, sref)
      send(16'h007f, 16'h2000);
      `CHK("ignored word keeps ref", 16'h7fff, sref)
   endtask
   task automatic t_setup();
      for (int s = 0; s < 4; s++) begin
         send({1'b0, s[1:0], 13'h047f}, 16'h0000);
         `CHK("setup select", s[1:0], setup)
      end
      @(posedge clk);
      mrun <= 1'b1;
      send(16'h047f, 16'h0000);
      `CHK("setup held while running", 2'h3, setup)
      @(posedge clk);
      mrun <= 1'b0;
      multi <= 1'b0;
      send(16'h047f, 16'h0000);
      `CHK("setup refused", 2'h3, setup)
      send(16'h847f, 16'h0000);
      `CHK("bus reverse", 1'b1, rev)
      @(posedge clk);
      sel <= 2'h0;
      din <= 1'b0;
      send(16'h847f, 16'h0000);
      `CHK("input reverse", 1'b0, rev)
   endtask
   task automatic end_of_test();
      if (err_total == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ==========================================
   // Clock, sequence, watchdog
   initial begin
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      #1;
      `CHK("stop after reset", 3'h1, stop_mode)
      `CHK("run after reset", 1'b0, run_en)
      t_fault();
      t_stops();
      t_ref();
      t_setup();
      end_of_test();
   end
   // Run needs some 230 cycles; about nine times that means a hang
   initial begin
      #20000;
      err_total++;
      end_of_test();
   end
endmodule
`default_nettype wire
